// >>> verilog/ctc_timer.sv
/*
 * compact 10-bit up-counting timer with its register set behind apb.
 * assumes one 25 MHz clock that also serves as system and high clock,
 * an external clock pin asynchronous to it, and a zero-wait apb master.
 */
// The APB interface to the registers and the address map are this design's own decisions.
// What this block does
// - pause bit high holds the count; counting resumes from it when low
// - clock select 000..100 picks sys/4, sys, high/16, high/64, time base
// - clock select 101 connects no source; counter never advances
// - codes 110 and 111 count rising and falling edges of external pin
// - clearing timer-on stops counting and keeps the residual count
// - timer-on rising edge zeroes the counter; software cannot write it
// - in compare mode timer-on rising edge forces output to initial level
// - 3-bit period value compares against counter bits 9..7, with bits 6..0 zero
// - period codes give 128 to 896 clocks; code 000 gives 1024
// - outside pwm mode, clear select zero lets a period match clear the counter
// - period code 000 lets the counter run to maximum and overflow
// - compare-a value readable and writable as low byte and high byte
// - counter readable, not writable, as low byte and high byte
// - unused high-byte bits 7..2 always read zero
// - low bytes pass through a shared buffer latched by high-byte access
// - mode 00 compare output, 10 pwm, 11 timer/counter, 01 undefined
// - compare-a value compares against all ten counter bits
// - overflow or selected match clears counter and raises interrupt
`timescale 1ns/100ps
`default_nettype none
module ctc_timer
(
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire ctc_pkg::ctc_apb_req_t apb_req,
   output var  ctc_pkg::ctc_apb_rsp_t apb_rsp,
   input  wire logic                  external_clock_pin,
   output var  logic                  timer_output_pin,
   output var  logic                  irq
);

   ctc_pkg::ctc_state_t state_reg;
   ctc_pkg::ctc_state_t state_next;

   // control fields as named views
   logic                 pause_control;
   logic                 timer_on;
   ctc_pkg::ctc_clksel_t clock_source_select;
   logic [2:0]           period_compare_bits;
   ctc_pkg::ctc_mode_t   operating_mode_select;
   ctc_pkg::ctc_ofs_t    output_function_select;
   logic                 output_initial_level;
   logic                 output_polarity;
   logic                 duty_period_swap;
   logic                 clear_source_select;

   assign pause_control          = state_reg.ctrl_a[ctc_pkg::A_PAUSE];
   assign timer_on               = state_reg.ctrl_a[ctc_pkg::A_ON];
   assign clock_source_select    = ctc_pkg::ctc_clksel_t'(
      state_reg.ctrl_a[ctc_pkg::A_CKSEL_HI:ctc_pkg::A_CKSEL_LO]);
   assign period_compare_bits    =
      state_reg.ctrl_a[ctc_pkg::A_PER_HI:ctc_pkg::A_PER_LO];
   assign operating_mode_select  = ctc_pkg::ctc_mode_t'(
      state_reg.ctrl_b[ctc_pkg::B_MODE_HI:ctc_pkg::B_MODE_LO]);
   assign output_function_select = ctc_pkg::ctc_ofs_t'(
      state_reg.ctrl_b[ctc_pkg::B_OFS_HI:ctc_pkg::B_OFS_LO]);
   assign output_initial_level   = state_reg.ctrl_b[ctc_pkg::B_INIT];
   assign output_polarity        = state_reg.ctrl_b[ctc_pkg::B_POL];
   assign duty_period_swap       = state_reg.ctrl_b[ctc_pkg::B_SWAP];
   assign clear_source_select    = state_reg.ctrl_b[ctc_pkg::B_CLRSEL];

   // counter datapath signals
   logic        tick;
   logic        on_rise;
   logic        advance;
   logic [10:0] inc;
   logic        ovf;
   logic        p_hit;
   logic        a_hit;
   logic        clr_on_p;
   logic        clr_on_a;
   logic [9:0]  duty;
   logic        pwm_active;

   // apb decode signals
   logic        setup;
   logic        done;
   logic        wr_done;
   logic        rd_done;
   logic        mapped;
   logic [31:0] rdata;

   // active edge of the selected counter clock, one-cycle enable
   always_comb
   begin
      case (clock_source_select)
         ctc_pkg::CK_SYS_DIV4:   tick = &state_reg.presc[1:0];
         ctc_pkg::CK_SYS:        tick = 1'b1;
         ctc_pkg::CK_HIGH_DIV16: tick = &state_reg.presc[3:0];
         ctc_pkg::CK_HIGH_DIV64: tick = &state_reg.presc;
         ctc_pkg::CK_TIMEBASE:
            tick = (state_reg.tbc_div == ctc_pkg::TBC_LAST);
         ctc_pkg::CK_RESERVED:   tick = 1'b0;
         ctc_pkg::CK_EXT_RISE:
            tick = state_reg.ext_s2 & ~state_reg.ext_s3;
         ctc_pkg::CK_EXT_FALL:
            tick = ~state_reg.ext_s2 & state_reg.ext_s3;
         default:                tick = 1'b0;
      endcase
   end

   // match and clear decisions, evaluated on the value the count moves to
   always_comb
   begin
      on_rise  = timer_on & ~state_reg.on_prev;
      advance  = timer_on & ~pause_control & tick & ~on_rise;
      inc      = {1'b0, state_reg.count} + 11'h001;
      ovf      = inc[10];
      // period match only at the first count of the 128-count window
      p_hit    = (period_compare_bits != 3'h0) &&
                 (inc[9:7] == period_compare_bits) &&
                 (inc[6:0] == 7'h00);
      a_hit    = (inc[9:0] == state_reg.cmp_a);
      // pwm swaps which comparator sets the period
      if (operating_mode_select == ctc_pkg::MODE_PWM)
      begin
         clr_on_p = ~duty_period_swap;
         clr_on_a = duty_period_swap;
         duty     = duty_period_swap ?
                    {period_compare_bits, 7'h00} : state_reg.cmp_a;
      end
      else
      begin
         clr_on_p = ~clear_source_select;
         clr_on_a = clear_source_select;
         duty     = state_reg.cmp_a;
      end
      pwm_active = (state_reg.count < duty);
   end

   // apb phase decode; zero wait states, answer prepared in setup
   always_comb
   begin
      setup   = apb_req.psel & ~apb_req.penable;
      done    = apb_req.psel & apb_req.penable & state_reg.rsp.pready;
      wr_done = done & apb_req.pwrite;
      rd_done = done & ~apb_req.pwrite;
      mapped  = 1'b1;
      rdata   = 32'h0000_0000;
      case (apb_req.paddr)
         ctc_pkg::ADDR_CTRL_A:  rdata[7:0] = state_reg.ctrl_a;
         ctc_pkg::ADDR_CTRL_B:  rdata[7:0] = state_reg.ctrl_b;
         ctc_pkg::ADDR_CNT_LO:  rdata[7:0] = state_reg.low_buf;
         ctc_pkg::ADDR_CNT_HI:  rdata[1:0] = state_reg.count[9:8];
         ctc_pkg::ADDR_CMPA_LO: rdata[7:0] = state_reg.low_buf;
         ctc_pkg::ADDR_CMPA_HI: rdata[1:0] = state_reg.cmp_a[9:8];
         ctc_pkg::ADDR_IRQ_ST:  rdata[1:0] = state_reg.irq_status;
         ctc_pkg::ADDR_IRQ_MSK: rdata[1:0] = state_reg.irq_mask;
         default:               mapped     = 1'b0;
      endcase
   end

   // next state of the whole block
   always_comb
   begin
      state_next = state_reg;

      // dividers run free so a source switch needs no restart
      state_next.presc   = state_reg.presc + 6'h01;
      state_next.tbc_div = (state_reg.tbc_div == ctc_pkg::TBC_LAST) ?
                           8'h00 : state_reg.tbc_div + 8'h01;

      // pin synchroniser; third flop only keeps edge history
      state_next.ext_s1 = external_clock_pin;
      state_next.ext_s2 = state_reg.ext_s1;
      state_next.ext_s3 = state_reg.ext_s2;

      state_next.on_prev = timer_on;

      // counter: zero on switch-on, otherwise step and auto-clear
      if (on_rise)
      begin
         state_next.count = 10'h000;
      end
      else if (advance)
      begin
         if (ovf || (p_hit && clr_on_p) || (a_hit && clr_on_a))
         begin
            state_next.count = 10'h000;
         end
         else
         begin
            state_next.count = inc[9:0];
         end
      end

      // timer output level per mode
      case (operating_mode_select)
         ctc_pkg::MODE_COMPARE:
         begin
            if (on_rise)
            begin
               state_next.out_level = output_initial_level;
            end
            else if (advance && a_hit)
            begin
               case (output_function_select)
                  ctc_pkg::OFS_LOW:    state_next.out_level = 1'b0;
                  ctc_pkg::OFS_HIGH:   state_next.out_level = 1'b1;
                  ctc_pkg::OFS_TOGGLE:
                     state_next.out_level = ~state_reg.out_level;
                  default:             state_next.out_level =
                                          state_reg.out_level;
               endcase
            end
         end
         ctc_pkg::MODE_PWM:
         begin
            case (output_function_select)
               ctc_pkg::OFS_HIGH:
                  state_next.out_level = timer_on & pwm_active;
               ctc_pkg::OFS_TOGGLE:
                  state_next.out_level = timer_on & ~pwm_active;
               default: state_next.out_level = 1'b0;
            endcase
         end
         // timer/counter and undefined mode keep the pin inactive
         default: state_next.out_level = 1'b0;
      endcase
      state_next.pin = state_reg.out_level ^ output_polarity;

      // sticky status: a new event wins over a clear in the same cycle
      state_next.irq_status = state_reg.irq_status;
      if (wr_done && apb_req.paddr == ctc_pkg::ADDR_IRQ_ST)
      begin
         state_next.irq_status = state_reg.irq_status &
                                 ~apb_req.pwdata[1:0];
      end
      if (advance && (ovf || p_hit))
      begin
         state_next.irq_status[ctc_pkg::IRQ_P] = 1'b1;
      end
      if (advance && a_hit)
      begin
         state_next.irq_status[ctc_pkg::IRQ_A] = 1'b1;
      end
      state_next.irq = |(state_next.irq_status & state_next.irq_mask);

      // register writes take effect at the completing edge only
      if (wr_done)
      begin
         case (apb_req.paddr)
            ctc_pkg::ADDR_CTRL_A:  state_next.ctrl_a = apb_req.pwdata[7:0];
            ctc_pkg::ADDR_CTRL_B:  state_next.ctrl_b = apb_req.pwdata[7:0];
            ctc_pkg::ADDR_CMPA_LO:
               state_next.low_buf = apb_req.pwdata[7:0];
            ctc_pkg::ADDR_CMPA_HI:
               state_next.cmp_a = {apb_req.pwdata[1:0],
                                   state_reg.low_buf};
            ctc_pkg::ADDR_IRQ_MSK:
               state_next.irq_mask = apb_req.pwdata[1:0];
            // counter bytes ignore writes
            default: state_next.low_buf = state_reg.low_buf;
         endcase
      end

      // high-byte reads latch the matching low byte into the buffer
      if (rd_done && apb_req.paddr == ctc_pkg::ADDR_CNT_HI)
      begin
         state_next.low_buf = state_reg.count[7:0];
      end
      if (rd_done && apb_req.paddr == ctc_pkg::ADDR_CMPA_HI)
      begin
         state_next.low_buf = state_reg.cmp_a[7:0];
      end

      // answer: ready rises for the access phase, drops after it
      if (setup)
      begin
         state_next.rsp.pready  = 1'b1;
         state_next.rsp.pslverr = ~mapped;
         state_next.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rdata;
      end
      else if (done)
      begin
         state_next.rsp.pready  = 1'b0;
         state_next.rsp.pslverr = 1'b0;
         state_next.rsp.prdata  = 32'h0000_0000;
      end
   end

   // single state register, constant reset values
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_reg            <= '0;
         state_reg.ctrl_a     <= ctc_pkg::CTRL_A_RST;
         state_reg.ctrl_b     <= ctc_pkg::CTRL_B_RST;
         state_reg.count      <= ctc_pkg::CNT_RST;
         state_reg.cmp_a      <= ctc_pkg::CMPA_RST;
         state_reg.irq_status <= ctc_pkg::IRQ_RST;
         state_reg.irq_mask   <= ctc_pkg::IRQ_RST;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // all outputs straight from the state register
   assign apb_rsp          = state_reg.rsp;
   assign timer_output_pin = state_reg.pin;
   assign irq              = state_reg.irq;

endmodule : ctc_timer
`default_nettype wire

// >>> common/ctc_pkg.sv
/*
 * constants, enumerations and carrier types of the compact timer block.
 * assumes a single 25 MHz clock and a 32-bit apb master with 12-bit address.
 */
`default_nettype none
package ctc_pkg;
   // clock and timing
   localparam int unsigned CLK_FREQ_HZ  = 25000000;
   localparam int unsigned TBC_DIV      = 256;
   localparam logic [7:0]  TBC_LAST     = 8'(TBC_DIV - 1);

   // register byte addresses
   localparam logic [11:0] ADDR_CTRL_A  = 12'h000;
   localparam logic [11:0] ADDR_CTRL_B  = 12'h004;
   localparam logic [11:0] ADDR_CNT_LO  = 12'h008;
   localparam logic [11:0] ADDR_CNT_HI  = 12'h00c;
   localparam logic [11:0] ADDR_CMPA_LO = 12'h010;
   localparam logic [11:0] ADDR_CMPA_HI = 12'h014;
   localparam logic [11:0] ADDR_IRQ_ST  = 12'h018;
   localparam logic [11:0] ADDR_IRQ_MSK = 12'h01c;

   // reset values
   localparam logic [7:0]  CTRL_A_RST   = 8'h00;
   localparam logic [7:0]  CTRL_B_RST   = 8'h00;
   localparam logic [9:0]  CNT_RST      = 10'h000;
   localparam logic [9:0]  CMPA_RST     = 10'h000;
   localparam logic [1:0]  IRQ_RST      = 2'h0;

   // timer_ctrl_a fields
   localparam int unsigned A_PAUSE      = 7;
   localparam int unsigned A_CKSEL_HI   = 6;
   localparam int unsigned A_CKSEL_LO   = 4;
   localparam int unsigned A_ON         = 3;
   localparam int unsigned A_PER_HI     = 2;
   localparam int unsigned A_PER_LO     = 0;

   // timer_ctrl_b fields
   localparam int unsigned B_MODE_HI    = 7;
   localparam int unsigned B_MODE_LO    = 6;
   localparam int unsigned B_OFS_HI     = 5;
   localparam int unsigned B_OFS_LO     = 4;
   localparam int unsigned B_INIT       = 3;
   localparam int unsigned B_POL        = 2;
   localparam int unsigned B_SWAP       = 1;
   localparam int unsigned B_CLRSEL     = 0;

   // interrupt status / mask bits
   localparam int unsigned IRQ_A        = 0;
   localparam int unsigned IRQ_P        = 1;

   typedef enum logic [2:0] {
      CK_SYS_DIV4  = 3'b000,
      CK_SYS       = 3'b001,
      CK_HIGH_DIV16 = 3'b010,
      CK_HIGH_DIV64 = 3'b011,
      CK_TIMEBASE  = 3'b100,
      CK_RESERVED  = 3'b101,
      CK_EXT_RISE  = 3'b110,
      CK_EXT_FALL  = 3'b111
   } ctc_clksel_t;

   typedef enum logic [1:0] {
      MODE_COMPARE = 2'b00,
      MODE_UNDEF   = 2'b01,
      MODE_PWM     = 2'b10,
      MODE_TIMER   = 2'b11
   } ctc_mode_t;

   typedef enum logic [1:0] {
      OFS_NONE   = 2'b00,
      OFS_LOW    = 2'b01,
      OFS_HIGH   = 2'b10,
      OFS_TOGGLE = 2'b11
   } ctc_ofs_t;

   // apb request and answer
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ctc_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } ctc_apb_rsp_t;

   // whole state of the timer
   typedef struct packed {
      logic [7:0]   ctrl_a;
      logic [7:0]   ctrl_b;
      logic [9:0]   count;
      logic [9:0]   cmp_a;
      logic [7:0]   low_buf;
      logic [1:0]   irq_status;
      logic [1:0]   irq_mask;
      logic         on_prev;
      logic [5:0]   presc;
      logic [7:0]   tbc_div;
      logic         ext_s1;
      logic         ext_s2;
      logic         ext_s3;
      logic         out_level;
      logic         pin;
      logic         irq;
      ctc_apb_rsp_t rsp;
   } ctc_state_t;
endpackage : ctc_pkg
`default_nettype wire

// >>> tb/ctc_checker.sv
/*
 * port checks of the compact timer, bound into ctc_timer.
 * assumes the ctc_pkg register map and a zero-wait apb slave.
 */
`timescale 1ns/100ps
`default_nettype none
module ctc_checker
(
   input wire logic                  clk,
   input wire logic                  reset,
   input wire ctc_pkg::ctc_apb_req_t apb_req,
   input wire ctc_pkg::ctc_apb_rsp_t apb_rsp,
   input wire logic                  external_clock_pin,
   input wire logic                  timer_output_pin,
   input wire logic                  irq
);
   logic [9:0]  cmpa_reg;
   logic [7:0]  buf_reg;
   logic [7:0]  ctlb_reg;
   logic [1:0]  mask_reg;
   logic        bok_reg;
   logic        on_reg;
   logic        done;
   logic        rdn;
   logic [11:0] a;
   logic [31:0] d;

   // completed transfer and completed read
   assign a    = apb_req.paddr;
   assign d    = apb_req.pwdata;
   assign done = apb_req.psel & apb_req.penable & apb_rsp.pready;
   assign rdn  = done & ~apb_req.pwrite;

   // shadow of writes; a counter high read leaves the buffer unknown
   // here, so the low-byte check waits until it is reloaded
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         {cmpa_reg, buf_reg, ctlb_reg, mask_reg} <= 28'h0;
         {bok_reg, on_reg} <= 2'h2;
      end
      else if (done && apb_req.pwrite)
      begin
         if (a == ctc_pkg::ADDR_CMPA_LO) {bok_reg, buf_reg} <= {1'b1, d[7:0]};
         if (a == ctc_pkg::ADDR_CMPA_HI) cmpa_reg <= {d[1:0], buf_reg};
         if (a == ctc_pkg::ADDR_CTRL_B) ctlb_reg <= d[7:0];
         if (a == ctc_pkg::ADDR_CTRL_A) on_reg <= d[3];
         if (a == ctc_pkg::ADDR_IRQ_MSK) mask_reg <= d[1:0];
      end
      else if (rdn && a == ctc_pkg::ADDR_CMPA_HI)
         {bok_reg, buf_reg} <= {1'b1, cmpa_reg[7:0]};
      else if (rdn && a == ctc_pkg::ADDR_CNT_HI)
         bok_reg <= 1'b0;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // setup phase, and a completed read of one register
   sequence s_setup;
      apb_req.psel && !apb_req.penable;
   endsequence
   sequence s_read(x);
      rdn && a == x;
   endsequence

   property p_zero_wait; s_setup |=> apb_rsp.pready; endproperty
   a_zero_wait: assert property (p_zero_wait)
      else $error("no answer in access cycle");
   property p_one_cycle; apb_rsp.pready |=> !apb_rsp.pready; endproperty
   a_one_cycle: assert property (p_one_cycle)
      else $error("ready held too long");
   property p_unmapped;
      s_setup ##0 (a > ctc_pkg::ADDR_IRQ_MSK)
         |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not refused");
   property p_hi_zero;
      rdn && (a == ctc_pkg::ADDR_CNT_HI || a == ctc_pkg::ADDR_CMPA_HI)
         |-> apb_rsp.prdata[31:2] == 30'h0;
   endproperty
   a_hi_zero: assert property (p_hi_zero)
      else $error("high byte upper bits set");
   property p_cmpa_hi;
      s_read(ctc_pkg::ADDR_CMPA_HI) |-> apb_rsp.prdata[1:0] == cmpa_reg[9:8];
   endproperty
   a_cmpa_hi: assert property (p_cmpa_hi)
      else $error("compare high byte mismatch");
   property p_buffer;
      s_read(ctc_pkg::ADDR_CMPA_LO)
         |-> !bok_reg || apb_rsp.prdata[7:0] == buf_reg;
   endproperty
   a_buffer: assert property (p_buffer)
      else $error("low byte not from buffer");
   property p_irq_mask; (mask_reg == 2'h0) [*2] |-> !irq; endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("irq with all sources masked");
   property p_pin_init;
      done && apb_req.pwrite && a == ctc_pkg::ADDR_CTRL_A && d[3] && !on_reg
         && ctlb_reg[7:4] == 4'h0
         |-> ##3 timer_output_pin == (ctlb_reg[3] ^ ctlb_reg[2]);
   endproperty
   a_pin_init: assert property (p_pin_init)
      else $error("pin not at initial level");
endmodule : ctc_checker

bind ctc_timer ctc_checker i_ctc_checker
(
   .clk(clk), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .external_clock_pin(external_clock_pin),
   .timer_output_pin(timer_output_pin), .irq(irq)
);
`default_nettype wire

// >>> tb/tb_ctc_timer.sv
/*
 * self-checking bench of the compact timer over apb.
 * assumes ctc_timer, ctc_pkg and the bound port checker.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module tb_ctc_timer;
   logic                  clk;
   logic                  reset;
   logic                  ext_pin;
   logic                  pin;
   logic                  irq;
   ctc_pkg::ctc_apb_req_t req;
   ctc_pkg::ctc_apb_rsp_t rsp;
   logic [31:0]           rd;
   logic                  err;
   logic [9:0]            c;
   logic [9:0]            c2;
   int                    miscompares;
   int                    compares;
   int                    dn;
   // clock codes, wait before pause, ticks expected
   logic [2:0]            ck_t [6] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
   int                    m_t  [6] = '{200, 800, 3200, 12800, 51200, 200};
   int                    e_t  [6] = '{203, 200, 200, 200, 200, 0};
   // irq runs: ctrl_a, ctrl_b, mask, cycles to irq, status
   logic [7:0]            ia_t [4] = '{8'h19, 8'h1b, 8'h18, 8'h18};
   logic [7:0]            ib_t [4] = '{8'h00, 8'h00, 8'h00, 8'h01};
   logic [1:0]            im_t [4] = '{2'h2, 2'h2, 2'h2, 2'h1};
   int                    ie_t [4] = '{128, 384, 1024, 677};
   logic [1:0]            is_t [4] = '{2'h2, 2'h2, 2'h3, 2'h1};

   ctc_timer i_ctc_timer
   (
      .clk                (clk),
      .reset              (reset),
      .apb_req            (req),
      .apb_rsp            (rsp),
      .external_clock_pin (ext_pin),
      .timer_output_pin   (pin),
      .irq                (irq)
   );

   // 25 MHz clock
   always #20 clk = ~clk;

   task automatic check(string n, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : check

   // one apb transfer; request stands until ready is sampled high,
   // and only the watchdog ends a wait that never gets an answer
   task automatic xfer(logic w, logic [11:0] ad, logic [31:0] wd);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: wd};
      @(posedge clk);
      req.penable <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (rsp.pready !== 1'b1);
      rd  = rsp.prdata;
      err = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
      @(posedge clk);
   endtask : xfer

   task automatic wr(logic [11:0] ad, logic [31:0] wd);
      xfer(1'b1, ad, wd);
   endtask : wr

   task automatic wa(logic [31:0] wd);
      xfer(1'b1, ctc_pkg::ADDR_CTRL_A, wd);
   endtask : wa

   // high byte first so the low byte comes from the same snapshot
   task automatic get_cnt(output logic [9:0] v);
      xfer(1'b0, ctc_pkg::ADDR_CNT_HI, 32'h0);
      v[9:8] = rd[1:0];
      xfer(1'b0, ctc_pkg::ADDR_CNT_LO, 32'h0);
      v[7:0] = rd[7:0];
   endtask : get_cnt

   // arm one event source and time the interrupt from switch-on
   task automatic run_irq(int i);
      int n;
      n = 0;
      wa(32'h0);
      wr(ctc_pkg::ADDR_CTRL_B, {24'h0, ib_t[i]});
      wr(ctc_pkg::ADDR_IRQ_MSK, {30'h0, im_t[i]});
      wr(ctc_pkg::ADDR_IRQ_ST, 32'h3);
      wa({24'h0, ia_t[i]});
      while (irq !== 1'b1 && n < 1100)
      begin
         @(posedge clk);
         n++;
      end
      `CHK("irq delay", 1'b1, n >= ie_t[i] - 2 && n <= ie_t[i] + 3);
      xfer(1'b0, ctc_pkg::ADDR_IRQ_ST, 32'h0);
      `CHK("status", is_t[i], rd);
      wr(ctc_pkg::ADDR_IRQ_ST, {30'h0, is_t[i]});
      `CHK("irq cleared", 1'b0, irq);
   endtask : run_irq

   task automatic end_sim();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim

   // hang guard; the run needs some 73000 cycles
   initial
   begin
      repeat (90000) @(posedge clk);
      miscompares++;
      end_sim();
   end

   initial
   begin
      clk     = 1'b0;
      reset   = 1'b1;
      ext_pin = 1'b0;
      req     = '0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      // all registers zero after reset; the word past the map is refused
      for (int i = 0; i < 9; i++)
      begin
         xfer(1'b0, 12'(4 * i), 32'h0);
         `CHK("reset value", 32'h0, rd);
         `CHK("error flag", i == 8, err);
      end
      // compare value pair through the shared low-byte buffer
      wr(ctc_pkg::ADDR_CMPA_LO, 32'h0000_00a5);
      wr(ctc_pkg::ADDR_CMPA_HI, 32'hffff_fffe);
      wr(ctc_pkg::ADDR_CMPA_LO, 32'h0000_003c);
      xfer(1'b0, ctc_pkg::ADDR_CMPA_HI, 32'h0);
      `CHK("compare high", 32'h2, rd);
      xfer(1'b0, ctc_pkg::ADDR_CMPA_LO, 32'h0);
      `CHK("compare low", 32'ha5, rd);
      // counter ignores writes
      wr(ctc_pkg::ADDR_CNT_LO, 32'hff);
      `CHK("count write error", 1'b0, err);
      wr(ctc_pkg::ADDR_CNT_HI, 32'h3);
      get_cnt(c);
      `CHK("count unwritten", 10'h0, c);
      for (int m = 0; m < 4; m++)
      begin
         wr(ctc_pkg::ADDR_CTRL_B, 32'(m) << 6);
         xfer(1'b0, ctc_pkg::ADDR_CTRL_B, 32'h0);
         `CHK("mode", 32'(m) << 6, rd);
      end
      // tick rate per source; pause and off keep the count
      for (int i = 0; i < 6; i++)
      begin
         wa({25'h0, ck_t[i], 4'h8});
         repeat (m_t[i]) @(posedge clk);
         wa({24'h0, 1'b1, ck_t[i], 4'h8});
         get_cnt(c);
         dn = int'(c) - e_t[i];
         `CHK("ticks", 1'b1, dn >= -2 && dn <= 2);
         repeat (50) @(posedge clk);
         get_cnt(c2);
         `CHK("paused count", c, c2);
         wa({25'h0, ck_t[i], 4'h0});
         get_cnt(c2);
         `CHK("residual count", c, c2);
      end
      // external pin edges, rising then falling
      for (int k = 6; k < 8; k++)
      begin
         wa(32'h0);
         wa({25'h0, 3'(k), 4'h8});
         repeat (5)
         begin
            ext_pin <= 1'b1;
            repeat (5) @(posedge clk);
            ext_pin <= 1'b0;
            repeat (5) @(posedge clk);
         end
         repeat (10) @(posedge clk);
         wa({24'h0, 1'b1, 3'(k), 4'h8});
         get_cnt(c);
         `CHK("edge count", 10'h005, c);
      end
      // switch-on in compare mode sets the initial pin level
      for (int k = 0; k < 2; k++)
      begin
         wa(32'h0);
         wr(ctc_pkg::ADDR_CTRL_B, k ? 32'h0c : 32'h08);
         wa(32'h18);
         repeat (3) @(posedge clk);
         `CHK("pin level", k == 0, pin);
      end
      // compare-a match at 677 drives the pin high in compare mode;
      // pwm with swap holds it high while the count is below 128
      for (int k = 0; k < 2; k++)
      begin
         wa(32'h0);
         wr(ctc_pkg::ADDR_CTRL_B, k ? 32'ha2 : 32'h20);
         wa(32'h18 + 32'(k));
         repeat (100) @(posedge clk);
         `CHK("pin early", k, pin);
         repeat (k ? 300 : 600) @(posedge clk);
         `CHK("pin late", k == 0, pin);
      end
      for (int i = 0; i < 4; i++)
         run_irq(i);
      end_sim();
   end
endmodule : tb_ctc_timer
`default_nettype wire
